// ---- core/adc_host_end.sv ----
`timescale 1ns/1ps
module adc_host_end #(
    parameter int RES_W    = adc_link_pkg::RES_BITS,
    parameter int SCK_HALF = adc_link_pkg::SCK_HALF_CYC,
    parameter int SETTLE   = adc_link_pkg::SETTLE_CYC
) (
    input  wire logic               sys_clk_in,
    input  wire logic               rst_in,
    input  wire logic               lvds_sel_in,
    input  wire logic               run_in,
    input  wire logic               power_step_in,
    input  wire logic               wake_in,
    input  wire logic               data_ready_in,
    output logic [RES_W-1:0]        data_out,
    output logic                    data_valid_out,
    output logic [1:0]              dev_mode_out,
    output logic                    settled_out,
    output logic                    busy_out,
    adc_link_if.host                link
);
    localparam int TW = $clog2(SETTLE + 1);
    localparam logic [TW-1:0] SETTLE_T = TW'(SETTLE);
    localparam logic [4:0] HALF_T = 5'(SCK_HALF - 1);
    localparam logic [4:0] HI_T   = 5'(adc_link_pkg::STROBE_HIGH_CYC - 1);
    localparam logic [4:0] GAP_T  = 5'(adc_link_pkg::STROBE_GAP_CYC - 1);
    localparam logic [3:0] LAST_B = 4'(RES_W - 1);

    // Shorter halves outrun the two-way sync delay
    if (SCK_HALF < 8 || SCK_HALF > 32 || RES_W > 15 || SETTLE < 1)
    begin : g_chk
        $error("adc_host_end: parameter out of range");
    end

    typedef struct packed {
        adc_link_pkg::host_state_t st;
        logic [4:0]              ph;
        logic [3:0]              bit_idx;
        logic                    pwr_only;
        logic [RES_W-1:0]        sh;
        logic                    strobe;
        logic                    sck;
        logic [1:0]              sdop_s;
        logic [1:0]              sdon_s;
        logic [2:0]              idle_cnt;
        logic                    seen;
        logic                    discard;
        logic [TW-1:0]           settle;
        logic [1:0][RES_W-1:0]   mem;
        logic                    wr_ptr;
        logic                    rd_ptr;
        logic [1:0]              fill;
    } host_state_t;

    host_state_t state_r;
    host_state_t state_nxt;
    adc_link_pkg::pwr_mode_t mode;
    logic                    sdo_lvl;
    logic                    push;
    logic                    pop;

    // Line decode from second sync stages
    always_comb begin
        mode    = adc_link_pkg::mode_of(state_r.idle_cnt);
        sdo_lvl = lvds_sel_in ? (state_r.sdop_s[1] & ~state_r.sdon_s[1])
                              : state_r.sdop_s[1];
        pop     = data_ready_in && state_r.fill != 2'h0;
    end

    // Sequencer, power tracking and two-entry buffer
    always_comb begin
        state_nxt = state_r;
        push = 1'b0;
        state_nxt.sdop_s = {state_r.sdop_s[0], link.sdo_p};
        state_nxt.sdon_s = {state_r.sdon_s[0], link.sdo_n};
        if (state_r.settle != '0) begin
            state_nxt.settle = state_r.settle - 1'b1;
        end
        state_nxt.ph = state_r.ph + 5'h1;
        case (state_r.st)
            adc_link_pkg::H_IDLE: begin
                state_nxt.ph = 5'h0;
                if (wake_in) begin
                    state_nxt.st  = adc_link_pkg::H_WAKE_HI;
                    state_nxt.sck = 1'b1;
                    state_nxt.discard = 1'b1;
                    if (mode == adc_link_pkg::PWR_NAP || (!lvds_sel_in
                        && mode == adc_link_pkg::PWR_SLEEP)) begin
                        state_nxt.idle_cnt = adc_link_pkg::CNT_RST;
                        state_nxt.seen = 1'b1;
                        if (mode == adc_link_pkg::PWR_SLEEP) begin
                            state_nxt.settle = SETTLE_T;
                        end
                    end
                end else if (power_step_in || (run_in
                             && state_r.settle == '0
                             && mode == adc_link_pkg::PWR_OP)) begin
                    state_nxt.st = adc_link_pkg::H_STB_HI;
                    state_nxt.strobe = 1'b1;
                    state_nxt.pwr_only = power_step_in;
                    state_nxt.discard = state_r.discard | power_step_in;
                    state_nxt.idle_cnt = adc_link_pkg::next_cnt(
                        state_r.idle_cnt, state_r.seen);
                    state_nxt.seen = 1'b0;
                    if (mode == adc_link_pkg::PWR_SLEEP) begin
                        state_nxt.settle = SETTLE_T;
                    end
                end
            end
            adc_link_pkg::H_STB_HI: begin
                if (state_r.ph == HI_T) begin
                    state_nxt.st = adc_link_pkg::H_STB_GAP;
                    state_nxt.strobe = 1'b0;
                    state_nxt.ph = 5'h0;
                end
            end
            adc_link_pkg::H_STB_GAP: begin
                if (state_r.ph == GAP_T) begin
                    state_nxt.ph = 5'h0;
                    state_nxt.bit_idx = 4'h0;
                    if (state_r.pwr_only) begin
                        state_nxt.st = adc_link_pkg::H_IDLE;
                    end else begin
                        state_nxt.st = adc_link_pkg::H_SCK_HI;
                        state_nxt.sck = 1'b1;
                        state_nxt.seen = 1'b1;
                    end
                end
            end
            adc_link_pkg::H_SCK_HI: begin
                if (state_r.ph == HALF_T) begin
                    state_nxt.st = adc_link_pkg::H_SCK_LO;
                    state_nxt.sck = 1'b0;
                    state_nxt.ph = 5'h0;
                end
            end
            adc_link_pkg::H_SCK_LO: begin
                if (state_r.ph == HALF_T) begin
                    // Capture just before the next rise
                    state_nxt.sh = {state_r.sh[RES_W-2:0], sdo_lvl};
                    state_nxt.ph = 5'h0;
                    state_nxt.bit_idx = state_r.bit_idx + 4'h1;
                    if (state_r.bit_idx == LAST_B) begin
                        state_nxt.st = adc_link_pkg::H_PUSH;
                    end else begin
                        state_nxt.st = adc_link_pkg::H_SCK_HI;
                        state_nxt.sck = 1'b1;
                    end
                end
            end
            adc_link_pkg::H_PUSH: begin
                // Full buffer stalls the sequencer here
                if (state_r.discard) begin
                    state_nxt.discard = 1'b0;
                    state_nxt.st = adc_link_pkg::H_IDLE;
                end else if (state_r.fill != 2'h2) begin
                    push = 1'b1;
                    state_nxt.mem[state_r.wr_ptr] = state_r.sh;
                    state_nxt.wr_ptr = ~state_r.wr_ptr;
                    state_nxt.st = adc_link_pkg::H_IDLE;
                end
            end
            adc_link_pkg::H_WAKE_HI: begin
                if (state_r.ph == HALF_T) begin
                    state_nxt.st = adc_link_pkg::H_WAKE_LO;
                    state_nxt.sck = 1'b0;
                    state_nxt.ph = 5'h0;
                end
            end
            adc_link_pkg::H_WAKE_LO: begin
                if (state_r.ph == HALF_T) begin
                    state_nxt.st = adc_link_pkg::H_IDLE;
                end
            end
            default: begin
                state_nxt.st = adc_link_pkg::H_IDLE;
            end
        endcase
        if (pop) begin
            state_nxt.rd_ptr = ~state_r.rd_ptr;
        end
        state_nxt.fill = state_r.fill + {1'b0, push} - {1'b0, pop};
    end

    // Reset acts as power-on: settle wait armed, first result dropped
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r         <= '0;
            state_r.settle  <= SETTLE_T;
            state_r.discard <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign link.strobe    = state_r.strobe;
    assign link.sck_p     = state_r.sck;
    assign link.sck_n     = lvds_sel_in & ~state_r.sck;
    assign data_out       = state_r.mem[state_r.rd_ptr];
    assign data_valid_out = state_r.fill != 2'h0;
    assign dev_mode_out   = mode;
    assign settled_out    = state_r.settle == '0;
    assign busy_out       = state_r.st != adc_link_pkg::H_IDLE;
endmodule // adc_host_end

// ---- core/adc_link_pkg.sv ----
package adc_link_pkg;
    // Result width, sign bit included
    localparam int RES_BITS      = 13;
    // System clock period
    localparam int CLK_PS        = 20000;
    // Typical strobe high time at full rate
    localparam int STROBE_HIGH_PS  = 38100;
    localparam int STROBE_HIGH_CYC = (STROBE_HIGH_PS + CLK_PS - 1) / CLK_PS;
    // Nominal link figures; not reachable from a 50 MHz divider
    localparam int SCK_NOM_MHZ   = 105;
    localparam int RATE_NOM_KSPS = 5000;
    // Settling wait after power-on or sleep exit
    localparam int SETTLE_MS     = 10;
    localparam int SETTLE_CYC    = SETTLE_MS * (1000000000 / CLK_PS);
    // Divider half period; covers sync delay on both ends
    localparam int SCK_HALF_CYC  = 8;
    localparam int STROBE_GAP_CYC = 4;
    // Idle strobe counts that mark the power states
    localparam logic [2:0] CNT_RST   = 3'h0;
    localparam logic [2:0] CNT_FIRST = 3'h1;
    localparam logic [2:0] CNT_NAP   = 3'h2;
    localparam logic [2:0] CNT_SLEEP = 3'h4;

    typedef enum logic [1:0] {
        PWR_OP    = 2'b00,
        PWR_NAP   = 2'b01,
        PWR_SLEEP = 2'b10
    } pwr_mode_t;

    typedef enum logic [2:0] {
        H_IDLE    = 3'b000,
        H_STB_HI  = 3'b001,
        H_STB_GAP = 3'b010,
        H_SCK_HI  = 3'b011,
        H_SCK_LO  = 3'b100,
        H_PUSH    = 3'b101,
        H_WAKE_HI = 3'b110,
        H_WAKE_LO = 3'b111
    } host_state_t;

    // Power state implied by the idle strobe count
    function automatic pwr_mode_t mode_of(input logic [2:0] cnt);
        if (cnt >= CNT_SLEEP) begin
            return PWR_SLEEP;
        end else if (cnt >= CNT_NAP) begin
            return PWR_NAP;
        end
        return PWR_OP;
    endfunction

    // Next idle count at a strobe rising edge
    function automatic logic [2:0] next_cnt(input logic [2:0] cnt,
                                            input logic       seen);
        if (seen || cnt >= CNT_SLEEP) begin
            return CNT_FIRST;
        end
        return cnt + 3'h1;
    endfunction
endpackage

// ---- core/adc_link_if.sv ----
`timescale 1ns/1ps
interface adc_link_if;
    logic strobe;   // Conversion strobe, host to device
    logic sck_p;    // Serial clock, positive leg
    logic sck_n;    // Serial clock, negative leg, low in CMOS
    logic sdo_p;    // Serial data, positive leg
    logic sdo_n;    // Serial data, negative leg, low in CMOS

    modport device (
        input  strobe,
        input  sck_p,
        input  sck_n,
        output sdo_p,
        output sdo_n
    );

    modport host (
        output strobe,
        output sck_p,
        output sck_n,
        input  sdo_p,
        input  sdo_n
    );
endinterface

// ---- core/adc_device_end.sv ----
`timescale 1ns/1ps
module adc_device_end #(
    parameter int RES_W = adc_link_pkg::RES_BITS
) (
    input  wire logic               sys_clk_in,
    input  wire logic               rst_in,
    input  wire logic               supply_ok_in,
    input  wire logic               lvds_sel_in,
    input  wire logic [RES_W-1:0]   sample_in,
    output logic [1:0]              mode_out,
    output logic                    sample_taken_out,
    adc_link_if.device              link
);
    localparam logic [3:0] BITS_ALL = 4'(RES_W);

    // Wider results would overrun the bit counter
    if (RES_W < 1 || RES_W > 15) begin : g_chk
        $error("adc_device_end: RES_W out of range");
    end

    typedef struct packed {
        logic [1:0]       stb_s;
        logic [1:0]       sckp_s;
        logic [1:0]       sckn_s;
        logic [1:0]       sup_s;
        logic [1:0]       lvds_s;
        logic             stb_d;
        logic             sck_d;
        logic [2:0]       idle_cnt;
        logic             sck_seen;
        logic [RES_W-1:0] sample;
        logic [RES_W-1:0] prev;
        logic [RES_W-1:0] shreg;
        logic [3:0]       bits_left;
        logic             sdo_p;
        logic             sdo_n;
        logic             taken;
    } dev_state_t;

    localparam dev_state_t DEV_RST = '0;

    dev_state_t state_r;
    dev_state_t state_nxt;

    logic                   lvds;
    logic                   sck_lvl;
    logic                   stb_rise;
    logic                   stb_fall;
    logic                   sck_rise;
    logic                   sck_fall;
    adc_link_pkg::pwr_mode_t mode;

    // Decoded link levels, all from second sync stages
    always_comb begin
        lvds    = state_r.lvds_s[1];
        sck_lvl = lvds ? (state_r.sckp_s[1] & ~state_r.sckn_s[1])
                       : state_r.sckp_s[1];
        stb_rise = state_r.stb_s[1] & ~state_r.stb_d;
        stb_fall = ~state_r.stb_s[1] & state_r.stb_d;
        sck_rise = sck_lvl & ~state_r.sck_d;
        sck_fall = ~sck_lvl & state_r.sck_d;
        mode     = adc_link_pkg::mode_of(state_r.idle_cnt);
    end

    // Next state of the whole end
    always_comb begin
        state_nxt = state_r;
        // Synchronisers keep running through supply loss
        state_nxt.stb_s  = {state_r.stb_s[0], link.strobe};
        state_nxt.sckp_s = {state_r.sckp_s[0], link.sck_p};
        state_nxt.sckn_s = {state_r.sckn_s[0], link.sck_n};
        state_nxt.sup_s  = {state_r.sup_s[0], supply_ok_in};
        state_nxt.lvds_s = {state_r.lvds_s[0], lvds_sel_in};
        state_nxt.stb_d  = state_r.stb_s[1];
        state_nxt.sck_d  = sck_lvl;
        state_nxt.taken  = 1'b0;

        if (!state_r.sup_s[1]) begin
            // Supply low: hold the converter in its reset state
            state_nxt.idle_cnt  = DEV_RST.idle_cnt;
            state_nxt.sck_seen  = DEV_RST.sck_seen;
            state_nxt.sample    = DEV_RST.sample;
            state_nxt.prev      = DEV_RST.prev;
            state_nxt.shreg     = DEV_RST.shreg;
            state_nxt.bits_left = DEV_RST.bits_left;
            state_nxt.sdo_p     = DEV_RST.sdo_p;
            state_nxt.sdo_n     = DEV_RST.sdo_n;
        end else begin
            // Clock rises: wake or mark activity
            if (sck_rise) begin
                case (mode)
                    adc_link_pkg::PWR_NAP: begin
                        state_nxt.idle_cnt = adc_link_pkg::CNT_RST;
                        state_nxt.sck_seen = 1'b1;
                    end
                    adc_link_pkg::PWR_SLEEP: begin
                        // LVDS sleep: clock rises do not wake, though falls still shift out pending bits
                        if (!lvds) begin
                            state_nxt.idle_cnt = adc_link_pkg::CNT_RST;
                            state_nxt.sck_seen = 1'b1;
                        end
                    end
                    default: begin
                        state_nxt.sck_seen = 1'b1;
                    end
                endcase
            end

            // Strobe rise: sample input, advance power count
            if (stb_rise) begin
                state_nxt.sample   = sample_in;
                // Count wraps past sleep back to operation
                state_nxt.idle_cnt = adc_link_pkg::next_cnt(
                    state_r.idle_cnt, state_r.sck_seen);
                state_nxt.sck_seen = 1'b0;
            end

            // Strobe fall: conversion starts, old result queued
            if (stb_fall) begin
                state_nxt.shreg     = state_r.prev;
                state_nxt.prev      = state_r.sample;
                state_nxt.bits_left = BITS_ALL;
                state_nxt.taken     = 1'b1;
            end else if (sck_fall && state_r.bits_left != 4'h0) begin
                // Bits move only on host clock edges
                state_nxt.sdo_p     = state_r.shreg[RES_W-1];
                state_nxt.sdo_n     = lvds & ~state_r.shreg[RES_W-1];
                state_nxt.shreg     = state_r.shreg << 1;
                state_nxt.bits_left = state_r.bits_left - 4'h1;
            end
        end
    end

    // State register; reset doubles as power-on
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= DEV_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Outputs straight from the state register, except mode_out, which is decoded from idle_cnt
    assign link.sdo_p       = state_r.sdo_p;
    assign link.sdo_n       = state_r.sdo_n;
    assign mode_out         = mode;
    assign sample_taken_out = state_r.taken;
endmodule // adc_device_end

// ---- testbench/adc_link_props.sv ----
`timescale 1ns/1ps
module adc_link_props (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic lvds_sel_in,
    input wire logic strobe,
    input wire logic sck_p,
    input wire logic sck_n,
    input wire logic sdo_p,
    input wire logic sdo_n
);
    logic       sck_q_r;
    logic [3:0] bits_r;

    // Clock rises since the last strobe; saturates so it cannot wrap
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sck_q_r <= 1'b0;
            bits_r  <= 4'h0;
        end else begin
            sck_q_r <= sck_p;
            if (strobe) begin
                bits_r <= 4'h0;
            end else if (sck_p && !sck_q_r && bits_r != 4'hf) begin
                bits_r <= bits_r + 4'h1;
            end
        end
    end

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    // Strobe high for two cycles, then low
    sequence s_strobe_pulse;
        strobe [*2] ##1 !strobe;
    endsequence
    // Serial clock high half of eight cycles
    sequence s_sck_high;
        sck_p [*8] ##1 !sck_p;
    endsequence

    // Link timing
    AST_STROBE_WIDTH: assert property ($rose(strobe) |-> s_strobe_pulse)
        else $error("strobe high time wrong");
    AST_STROBE_GAP: assert property (
        $fell(strobe) |-> (!strobe && !sck_p) [*4])
        else $error("clock too soon after strobe");
    AST_SCK_HIGH: assert property ($rose(sck_p) |-> s_sck_high)
        else $error("clock high half wrong");
    AST_SCK_LOW: assert property ($fell(sck_p) |-> !sck_p [*8])
        else $error("clock low half too short");
    AST_NO_STROBE_IN_CLOCK: assert property (sck_p |-> !strobe)
        else $error("strobe during clock high");
    AST_SDO_ON_LOW: assert property (
        $changed(sdo_p) |-> !sck_p && !$past(sck_p, 2))
        else $error("data moved outside clock low half");
    AST_BITS_PER_WORD: assert property (bits_r <= 4'hd)
        else $error("more than one word of clocks");
    // Pin pairing per select
    AST_CMOS_NEG_LOW: assert property (
        !lvds_sel_in |-> !sck_n && !sdo_n)
        else $error("negative leg active in single-ended mode");
    AST_LVDS_CLK_PAIR: assert property (
        lvds_sel_in |-> sck_n == !sck_p)
        else $error("clock pair not complementary");
    AST_LVDS_DATA_PAIR: assert property (
        lvds_sel_in && $changed(sdo_p) |-> sdo_n != sdo_p)
        else $error("data pair not complementary");
endmodule // adc_link_props

// ---- testbench/sar_adc_serial_readout_power_modes_bench.sv ----
`timescale 1ns/1ps
module sar_adc_serial_readout_power_modes_bench;
    localparam int W = adc_link_pkg::RES_BITS;
    localparam logic [W-1:0] TBL [8] = '{13'h1fff, 13'h0000, 13'h1555,
        13'h0aaa, 13'h1001, 13'h0ffe, 13'h0123, 13'h1abc};
    localparam logic [1:0] STEPS [8] = '{2'h0, 2'h1, 2'h1, 2'h2,
        2'h0, 2'h1, 2'h1, 2'h2};
    logic         sys_clk_in;
    logic         rst_in;
    logic         lvds_sel;
    logic         run;
    logic [1:0]   go;
    logic         ready;
    logic [1:0]   mode;
    logic         taken;
    logic [W-1:0] data;
    logic         valid;
    logic [1:0]   dev_mode;
    logic         settled;
    logic         busy;
    logic [2:0]   idx;
    logic [3:0]   nbit;
    logic [W-1:0] shift;
    logic [3:0]   lo_cnt;
    logic [W-1:0] mon_q [$];
    int           fails;
    int           n_tests;
    int           cyc;

    adc_link_if link ();

    adc_device_end u_adc_device_end (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .supply_ok_in(1'b1),
        .lvds_sel_in(lvds_sel), .sample_in(TBL[idx]), .mode_out(mode),
        .sample_taken_out(taken), .link(link));

    adc_host_end #(.SETTLE(60)) u_adc_host_end (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .lvds_sel_in(lvds_sel),
        .run_in(run), .power_step_in(go[0]), .wake_in(go[1]),
        .data_ready_in(ready), .data_out(data), .data_valid_out(valid),
        .dev_mode_out(dev_mode), .settled_out(settled), .busy_out(busy),
        .link(link));

    adc_link_props u_adc_link_props (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .lvds_sel_in(lvds_sel),
        .strobe(link.strobe), .sck_p(link.sck_p), .sck_n(link.sck_n),
        .sdo_p(link.sdo_p), .sdo_n(link.sdo_n));

    initial begin
        sys_clk_in = 1'b0;
        forever #10 sys_clk_in = ~sys_clk_in;
    end

    // Wire monitor, sample stepping and hang guard
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        // Cycles since the clock went low; data settles a few in
        if (rst_in) begin
            lo_cnt <= 4'hf;
        end else if (link.sck_p) begin
            lo_cnt <= 4'h0;
        end else if (lo_cnt != 4'hf) begin
            lo_cnt <= lo_cnt + 4'h1;
        end
        if (cyc == 12000) begin
            fails++;
            stop_test();
        end
        if (rst_in || link.strobe) begin
            nbit <= 4'h0;
        end else if (!link.sck_p && lo_cnt == 4'h5) begin
            // Sample mid low half: a bit launched by a fall stands here
            shift <= {shift[W-2:0], link.sdo_p};
            nbit <= nbit + 4'h1;
            if (nbit == 4'hc) begin
                mon_q.push_back({shift[W-2:0], link.sdo_p});
            end
        end
        if (rst_in) begin
            idx <= 3'h0;
        end else if (taken) begin
            idx <= idx + 3'h1;
        end
    end

    task automatic check(input string nm, input logic [W-1:0] seen,
                         input logic [W-1:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic wait_idle();
        @(negedge sys_clk_in);
        for (int n = 0; n < 400 && busy !== 1'b0; n++) @(negedge sys_clk_in);
    endtask

    // One host command; device needs a few cycles to sync the pins
    task automatic pulse(input logic [1:0] g);
        wait_idle();
        @(posedge sys_clk_in);
        go <= g;
        @(posedge sys_clk_in);
        go <= 2'b00;
        repeat (2) @(posedge sys_clk_in);
        wait_idle();
        repeat (8) @(negedge sys_clk_in);
    endtask

    task automatic do_reset(input logic lv);
        rst_in <= 1'b1;
        lvds_sel <= lv;
        run <= 1'b0;
        go <= 2'b00;
        ready <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        mon_q.delete();
        @(negedge sys_clk_in);
        check("reset mode", mode, 0);
        check("reset valid", valid, 0);
        check("reset sck_n", link.sck_n, lv);
        check("early settle", settled, 0);
        for (int n = 0; n < 200 && settled !== 1'b1; n++) @(negedge sys_clk_in);
        check("settled", settled, 1);
    endtask

    // Receiver stalls until the buffer is full, then drains it
    task automatic convert();
        int nq;
        int got;
        got = 0;
        @(posedge sys_clk_in);
        run <= 1'b1;
        repeat (1000) @(posedge sys_clk_in);
        nq = mon_q.size();
        repeat (400) @(posedge sys_clk_in);
        check("stall words", 13'(mon_q.size()), 13'(nq));
        check("stall valid", valid, 1);
        run <= 1'b0;
        ready <= 1'b1;
        @(negedge sys_clk_in);
        for (int n = 0; n < 2000 && (busy !== 1'b0 || valid !== 1'b0); n++)
        begin
            if (valid === 1'b1) begin
                check("word", data, TBL[got[2:0]]);
                got++;
            end
            @(negedge sys_clk_in);
        end
        check("word count", 13'(got), 13'(mon_q.size() - 1));
        check("wire first", mon_q[0], 0);
        for (int i = 1; i < mon_q.size(); i++) begin
            check("wire word", mon_q[i], TBL[i-1]);
        end
        check("op after run", mode, 0);
        $display("Conversion test done");
    endtask

    task automatic power(input logic lv);
        for (int i = 0; i < 8; i++) begin
            pulse(2'b01);
            check("mode", mode, STEPS[i]);
            check("tracked mode", dev_mode, STEPS[i]);
            if (i == 4) check("settle rearm", settled, 0);
        end
        pulse(2'b10);
        check("sleep wake", mode, lv ? 2'h2 : 2'h0);
        check("tracked wake", dev_mode, lv ? 2'h2 : 2'h0);
        if (!lv) check("wake rearm", settled, 0);
        pulse(2'b01);
        check("after wake step", mode, 0);
        pulse(2'b01);
        check("nap again", mode, 1);
        pulse(2'b10);
        check("nap wake", mode, 0);
        $display("Power test done");
    endtask

    initial begin
        do_reset(1'b0);
        convert();
        power(1'b0);
        do_reset(1'b1);
        convert();
        power(1'b1);
        stop_test();
    end
endmodule // sar_adc_serial_readout_power_modes_bench
